//--- verilog/umcs_modem.sv
// Modem handshake control and status with an Avalon-MM register slave
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "umcs_params.svh"
module umcs_modem (
  input  wire logic                core_clk_i,
  input  wire logic                arst_n_i,
  input  wire umcs_pkg::umcs_addr_t avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire umcs_pkg::umcs_word_t avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output umcs_pkg::umcs_word_t     avs_readdata_o,
  output logic                     avs_waitrequest_o,
  output logic                     irq_o,
  input  wire logic                clear_to_send_n_i,
  input  wire logic                data_set_ready_n_i,
  input  wire logic                ring_indicator_n_i,
  input  wire logic                carrier_detect_n_i,
  output logic                     terminal_ready_n_o,
  output logic                     request_to_send_n_o
);
  import umcs_pkg::*;

  // ========================================================================
  // Declarations
  umcs_bus_st_t bus_st_r;
  logic         wait_r;
  umcs_word_t   rdata_r;
  umcs_mdm_t    rd_snap_r;
  logic [4:0]   modem_control_reg_r;
  logic [3:0]   ier_r;
  logic [7:0]   scratch_r;
  umcs_mdm_t    evt_stat_r;
  umcs_mdm_t    evt_en_r;
  logic         irq_r;
  logic         dtr_n_r;
  logic         rts_n_r;
  logic         ring_prev_r;
  logic         ring_primed_r;
  logic         ring_lead_r;
  logic         ring_lead;

  logic         bus_req;
  logic         accept;
  logic         wr_lane0;
  logic         rd_msr;
  umcs_mdm_t    pin_level;
  umcs_mdm_t    loop_level;
  umcs_mdm_t    mdm_level;
  umcs_mdm_t    delta;
  umcs_mdm_t    change;
  umcs_mdm_t    delta_clr;
  umcs_mdm_t    evt_clr;
  logic [7:0]   modem_status_reg;
  logic         loop_on;

  // ========================================================================
  // Register write and read strobes
  // A request is taken at the edge where waitrequest is seen low
  assign bus_req  = avs_read_i | avs_write_i;
  assign accept   = bus_req & (bus_st_r == UMCS_BUS_ANSWER);
  assign wr_lane0 = accept & avs_write_i & avs_byteenable_i[0];
  assign rd_msr   = accept & avs_read_i
                  & umcs_hit(avs_address_i, `UMCS_IDX_MSR);

  // Write-one-to-clear of the event status, lane 0 only
  assign evt_clr = (wr_lane0 & umcs_hit(avs_address_i, `UMCS_IDX_EVT_CLR))
                 ? avs_writedata_i[3:0] : 4'h0;

  // Only the change bits that software actually saw are cleared, so a
  // change landing between the data capture and the taking edge survives
  assign delta_clr = rd_msr ? rd_snap_r : 4'h0;

  // ========================================================================
  // Modem line levels, asserted high
  assign loop_on = modem_control_reg_r[`UMCS_MCR_LOOP];

  // Pins are active low, status shows them inverted
  always_comb
  begin
    pin_level                  = '0;
    pin_level[`UMCS_LINE_CTS]  = ~clear_to_send_n_i;
    pin_level[`UMCS_LINE_DSR]  = ~data_set_ready_n_i;
    pin_level[`UMCS_LINE_RI]   = ~ring_indicator_n_i;
    pin_level[`UMCS_LINE_DCD]  = ~carrier_detect_n_i;
  end

  // In loopback the control bits feed the status lines instead of the pins
  always_comb
  begin
    loop_level                 = '0;
    loop_level[`UMCS_LINE_CTS] = modem_control_reg_r[`UMCS_MCR_RTS];
    loop_level[`UMCS_LINE_DSR] = modem_control_reg_r[`UMCS_MCR_DTR];
    loop_level[`UMCS_LINE_RI]  = modem_control_reg_r[`UMCS_MCR_OUT1];
    loop_level[`UMCS_LINE_DCD] = modem_control_reg_r[`UMCS_MCR_OUT2];
  end

  assign mdm_level = loop_on ? loop_level : pin_level;

  // ========================================================================
  // Change detection
  // Ring flags only on its trailing edge, the others on any edge
  umcs_delta u_delta (
    .core_clk_i   (core_clk_i),
    .arst_n_i     (arst_n_i),
    .level_i      (mdm_level),
    .trail_only_i (`UMCS_TRAIL_ONLY),
    .clear_i      (delta_clr),
    .delta_o      (delta),
    .change_o     (change)
  );

  // Upper nibble live line states, lower nibble sticky change bits
  assign modem_status_reg = {mdm_level, delta};

  // ========================================================================
  // Ring leading edge
  // The ring change bit flags only the trailing edge, yet a ring that
  // starts must still interrupt; this flag holds that edge until the
  // next status read, which drops it like the change bits
  assign ring_lead = ring_primed_r & mdm_level[`UMCS_LINE_RI] & ~ring_prev_r;

  // History skips the first cycle so a ring held through reset is no edge
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ring_prev_r   <= 1'b0;
      ring_primed_r <= 1'b0;
    end
    else
    begin
      ring_prev_r   <= mdm_level[`UMCS_LINE_RI];
      ring_primed_r <= 1'b1;
    end
  end

  // A new leading edge beats a status read in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ring_lead_r <= 1'b0;
    else
      ring_lead_r <= (ring_lead_r & ~rd_msr) | ring_lead;
  end

  // ========================================================================
  // Read data selection
  function automatic umcs_word_t read_value(umcs_addr_t addr);
    umcs_word_t v;
    v = '0;
    if (umcs_hit(addr, `UMCS_IDX_IER))
      v[3:0] = ier_r;
    else if (umcs_hit(addr, `UMCS_IDX_MCR))
      v[4:0] = modem_control_reg_r;
    else if (umcs_hit(addr, `UMCS_IDX_MSR))
      v[7:0] = modem_status_reg;
    else if (umcs_hit(addr, `UMCS_IDX_SCR))
      v[7:0] = scratch_r;
    else if (umcs_hit(addr, `UMCS_IDX_EVT_STAT))
      v[3:0] = evt_stat_r;
    else if (umcs_hit(addr, `UMCS_IDX_EVT_EN))
      v[3:0] = evt_en_r;
    return v;
  endfunction

  // ========================================================================
  // Avalon-MM handshake
  // Fixed one wait cycle: data is prepared in the idle cycle, waitrequest
  // drops for exactly one cycle, and the request is taken at that edge
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bus_st_r <= UMCS_BUS_IDLE;
      wait_r   <= 1'b1;
    end
    else
    begin
      case (bus_st_r)
        UMCS_BUS_IDLE:
        begin
          if (bus_req)
          begin
            bus_st_r <= UMCS_BUS_ANSWER;
            wait_r   <= 1'b0;
          end
        end
        UMCS_BUS_ANSWER:
        begin
          bus_st_r <= UMCS_BUS_IDLE;
          wait_r   <= 1'b1;
        end
        default:
        begin
          bus_st_r <= UMCS_BUS_IDLE;
          wait_r   <= 1'b1;
        end
      endcase
    end
  end

  // Read data and the change bits it reports, held through the answer
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_r   <= '0;
      rd_snap_r <= '0;
    end
    else if ((bus_st_r == UMCS_BUS_IDLE) && avs_read_i)
    begin
      rdata_r   <= read_value(avs_address_i);
      rd_snap_r <= delta;
    end
    else if (bus_st_r == UMCS_BUS_IDLE)
    begin
      rdata_r   <= '0; // Idle and write answers read as zero
      rd_snap_r <= '0;
    end
  end

  // ========================================================================
  // Control registers
  // Modem control register, only the low five bits are implemented
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      modem_control_reg_r <= `UMCS_MCR_RST;
    else if (wr_lane0 && umcs_hit(avs_address_i, `UMCS_IDX_MCR))
      modem_control_reg_r <= avs_writedata_i[4:0];
  end

  // Interrupt enable, bit 3 gates the modem status interrupt
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ier_r <= `UMCS_IER_RST;
    else if (wr_lane0 && umcs_hit(avs_address_i, `UMCS_IDX_IER))
      ier_r <= avs_writedata_i[3:0];
  end

  // Scratch byte, no side effects
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      scratch_r <= `UMCS_SCR_RST;
    else if (wr_lane0 && umcs_hit(avs_address_i, `UMCS_IDX_SCR))
      scratch_r <= avs_writedata_i[7:0];
  end

  // ========================================================================
  // Event status, enable and interrupt
  // Event bits share the change-bit layout; a set beats a clear
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      evt_stat_r <= `UMCS_EVT_RST;
    else
      evt_stat_r <= (evt_stat_r & ~evt_clr) | change;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      evt_en_r <= `UMCS_EVT_RST;
    else if (wr_lane0 && umcs_hit(avs_address_i, `UMCS_IDX_EVT_EN))
      evt_en_r <= avs_writedata_i[3:0];
  end

  // Level interrupt; the classic path follows the change bits so a status
  // read drops it, the event path needs an explicit clear
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_r <= 1'b0;
    else
      irq_r <= (ier_r[`UMCS_IER_MSI] & ((|delta) | ring_lead_r))
             | (|(evt_stat_r & evt_en_r));
  end

  // ========================================================================
  // Modem control outputs
  // Outputs lag a control write by one cycle; loopback parks both high
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dtr_n_r <= 1'b1;
      rts_n_r <= 1'b1;
    end
    else
    begin
      dtr_n_r <= ~modem_control_reg_r[`UMCS_MCR_DTR] | loop_on;
      rts_n_r <= ~modem_control_reg_r[`UMCS_MCR_RTS] | loop_on;
    end
  end

  // ========================================================================
  // Port assignments, all from flip-flops
  assign avs_readdata_o      = rdata_r;
  assign avs_waitrequest_o   = wait_r;
  assign irq_o               = irq_r;
  assign terminal_ready_n_o  = dtr_n_r;
  assign request_to_send_n_o = rts_n_r;

endmodule // umcs_modem

//--- verilog/umcs_params.svh
// Constants of the modem control and status block: offsets, fields, resets
//
// Contract
// - Status bit 6 reads one while the active-low ring input is low.
// - A ring input going low to high since the last status read sets bit 2.
// - Status bit 5 reads one while the active-low set-ready input is low.
// - Any change of the set-ready input since the last status read sets bit 1.
// - Status bit 7 reads one while the active-low carrier input is low.
// - Any change of the carrier input since the last status read sets bit 3.
// - With enable bit 3 set, a change of a modem input raises the interrupt.
// - The terminal-ready output follows control bit 0, active low.
// - The request-to-send output follows control bit 1, active low.
// - Reset leaves the request-to-send output high, inactive.
// - Loopback forces the request-to-send output inactive.
// - Reset and loopback leave the terminal-ready output inactive.
// - Status bit 4 is the inverted send-clear input; its change sets bit 0.
`ifndef UMCS_PARAMS_SVH
`define UMCS_PARAMS_SVH

// ==========================================================================
// Register indices, byte address is four times the index
`define UMCS_IDX_IER      4'h1
`define UMCS_IDX_MCR      4'h4
`define UMCS_IDX_MSR      4'h6
`define UMCS_IDX_SCR      4'h7
`define UMCS_IDX_EVT_STAT 4'h8
`define UMCS_IDX_EVT_CLR  4'h9
`define UMCS_IDX_EVT_EN   4'ha

// ==========================================================================
// Field positions
`define UMCS_MCR_DTR      0
`define UMCS_MCR_RTS      1
`define UMCS_MCR_OUT1     2
`define UMCS_MCR_OUT2     3
`define UMCS_MCR_LOOP     4
`define UMCS_IER_MSI      3
`define UMCS_LINE_CTS     0
`define UMCS_LINE_DSR     1
`define UMCS_LINE_RI      2
`define UMCS_LINE_DCD     3

// ==========================================================================
// Reset values and fixed masks
`define UMCS_MCR_RST      5'h00
`define UMCS_IER_RST      4'h0
`define UMCS_SCR_RST      8'h00
`define UMCS_EVT_RST      4'h0
`define UMCS_TRAIL_ONLY   4'h4

`endif

//--- verilog/umcs_pkg.sv
// Types and decode helpers of the modem control and status block
package umcs_pkg;

  typedef logic [31:0] umcs_word_t;
  typedef logic [5:0]  umcs_addr_t;
  typedef logic [3:0]  umcs_idx_t;
  typedef logic [3:0]  umcs_mdm_t;

  // Bus handshake phases
  typedef enum logic [0:0] {
    UMCS_BUS_IDLE,
    UMCS_BUS_ANSWER
  } umcs_bus_st_t;

  // Word-aligned register hit, byte lane bits are ignored
  function automatic logic umcs_hit(umcs_addr_t addr, umcs_idx_t idx);
    return (addr[5:2] == idx);
  endfunction

endpackage

//--- verilog/umcs_delta.sv
// Change detector and sticky change bits of the four modem lines
`timescale 1ns/100ps
`include "umcs_params.svh"
module umcs_delta (
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  input  wire umcs_pkg::umcs_mdm_t level_i,
  input  wire umcs_pkg::umcs_mdm_t trail_only_i,
  input  wire umcs_pkg::umcs_mdm_t clear_i,
  output umcs_pkg::umcs_mdm_t    delta_o,
  output umcs_pkg::umcs_mdm_t    change_o
);
  import umcs_pkg::*;

  umcs_mdm_t prev_r;
  umcs_mdm_t delta_r;
  logic      primed_r;

  // ========================================================================
  // Edge detection
  // Lines marked trail-only flag only when an asserted line lets go
  always_comb
  begin
    change_o = '0;
    if (primed_r)
    begin
      change_o = ((prev_r ^ level_i) & ~trail_only_i)
               | (prev_r & ~level_i & trail_only_i);
    end
  end

  // First cycle after release only loads the history, so a line held
  // asserted through reset does not look like a change
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prev_r   <= '0;
      primed_r <= 1'b0;
    end
    else
    begin
      prev_r   <= level_i;
      primed_r <= 1'b1;
    end
  end

  // Sticky change bits, a new change beats a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      delta_r <= '0;
    else
      delta_r <= (delta_r & ~clear_i) | change_o;
  end

  assign delta_o = delta_r;

endmodule // umcs_delta

//--- tb/umcs_modem_chk.sv
// Port checker of the modem control and status block
`timescale 1ns/100ps
`include "umcs_params.svh"
module umcs_modem_chk (
  input wire logic                core_clk_i,
  input wire logic                arst_n_i,
  input wire umcs_pkg::umcs_addr_t avs_address_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire umcs_pkg::umcs_word_t avs_writedata_i,
  input wire logic [3:0]          avs_byteenable_i,
  input wire umcs_pkg::umcs_word_t avs_readdata_o,
  input wire logic                avs_waitrequest_o,
  input wire logic                irq_o,
  input wire logic                clear_to_send_n_i,
  input wire logic                data_set_ready_n_i,
  input wire logic                ring_indicator_n_i,
  input wire logic                carrier_detect_n_i,
  input wire logic                terminal_ready_n_o,
  input wire logic                request_to_send_n_o
);
  import umcs_pkg::*;
  // ====================
  // Helper state
  logic [3:0] pin_q;
  logic [2:0] stab_q;
  logic [2:0] wage_q;
  logic [4:0] mcr_q;
  wire  [3:0] pins = {carrier_detect_n_i, ring_indicator_n_i,
                      data_set_ready_n_i, clear_to_send_n_i};
  wire  take = !avs_waitrequest_o;
  wire  mcr_wr = take && avs_write_i && avs_byteenable_i[0] &&
                 avs_address_i[5:2] == `UMCS_IDX_MCR;
  wire  msr_rd = take && avs_read_i && avs_address_i[5:2] == `UMCS_IDX_MSR;

  // Ages saturate at 7 so stale history never wraps into a false match
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_q <= 4'hf;
      stab_q <= 3'h0;
      wage_q <= 3'h7;
      mcr_q <= 5'h00;
    end
    else
    begin
      pin_q <= pins;
      stab_q <= (pins != pin_q) ? 3'h0 : stab_q + {2'h0, stab_q != 3'h7};
      wage_q <= (take && avs_write_i) ? 3'h0 :
                wage_q + {2'h0, wage_q != 3'h7};
      if (mcr_wr)
        mcr_q <= avs_writedata_i[4:0];
    end
  end

  // ====================
  // Assertions
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_out_idle: assert property (
    !$past(arst_n_i) |-> request_to_send_n_o && terminal_ready_n_o)
    else $error("modem outputs active after reset");
  a_rts_ctrl: assert property (
    mcr_wr |=> ##1 request_to_send_n_o == !(mcr_q[1] && !mcr_q[4]))
    else $error("send request output wrong after control write");
  a_dtr_ctrl: assert property (
    mcr_wr |=> ##1 terminal_ready_n_o == !(mcr_q[0] && !mcr_q[4]))
    else $error("terminal ready output wrong after control write");
  a_out_hold: assert property (
    !$past(mcr_wr, 2) |-> $stable(request_to_send_n_o) &&
    $stable(terminal_ready_n_o))
    else $error("modem output moved without control write");
  a_wait_one: assert property (
    $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 take)
    else $error("request not answered after one wait cycle");
  a_wait_pulse: assert property (take |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_stat_level: assert property (
    msr_rd && stab_q >= 3'd4 && !mcr_q[4] |-> avs_readdata_o[7:4] == ~pins)
    else $error("status levels do not mirror the modem lines");
  a_delta_clear: assert property (
    (msr_rd && !mcr_q[4]) ##3 (msr_rd && stab_q >= 3'd6 && wage_q == 3'd7)
    |-> avs_readdata_o[3:0] == 4'h0)
    else $error("change bits survived a status read");
  a_irq_cause: assert property (
    $rose(irq_o) |-> stab_q <= 3'd3 || wage_q <= 3'd4)
    else $error("interrupt rose without line change or write");
  c_msr_read: cover property (msr_rd);
  c_irq_rise: cover property ($rose(irq_o));
  c_loop_on: cover property (mcr_wr && avs_writedata_i[4]);
endmodule // umcs_modem_chk

bind umcs_modem umcs_modem_chk chk (.*);

//--- tb/umcs_mdm_model.sv
// Modem partner model driving the four active-low status lines
`timescale 1ns/100ps
`include "umcs_params.svh"
module umcs_mdm_model (
  input  wire logic       core_clk_i,
  input  wire logic [3:0] assert_i,
  input  wire logic       terminal_ready_n_i,
  input  wire logic       request_to_send_n_i,
  output logic            clear_to_send_n_o,
  output logic            data_set_ready_n_o,
  output logic            ring_indicator_n_o,
  output logic            carrier_detect_n_o,
  output logic            link_up_o
);
  // Lines idle high from time zero, then move just after an edge
  initial
  begin
    {clear_to_send_n_o, data_set_ready_n_o} = 2'h3;
    {ring_indicator_n_o, carrier_detect_n_o} = 2'h3;
  end
  always @(posedge core_clk_i)
  begin
    clear_to_send_n_o <= !assert_i[`UMCS_LINE_CTS];
    data_set_ready_n_o <= !assert_i[`UMCS_LINE_DSR];
    ring_indicator_n_o <= !assert_i[`UMCS_LINE_RI];
    carrier_detect_n_o <= !assert_i[`UMCS_LINE_DCD];
  end
  // Link counts as up only with both handshake outputs low
  assign link_up_o = !terminal_ready_n_i && !request_to_send_n_i;
endmodule // umcs_mdm_model

//--- tb/uart_modem_control_status_tb.sv
// Self-checking bench of the modem control and status block
`timescale 1ns/100ps
`include "umcs_params.svh"
module uart_modem_control_status_tb;
  import umcs_pkg::*;
  // ====================
  // Signals
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  umcs_addr_t addr = '0;
  logic       rd = 1'b0;
  logic       wr = 1'b0;
  umcs_word_t wdat = '0;
  logic [3:0] be = 4'hf;
  logic [3:0] lvl = 4'h0;
  umcs_word_t rdat;
  logic       wreq, irq, cts_n, dsr_n, ri_n, carrier_detect_n, dtr_n, rts_n, link;
  int         failures = 0;
  int         n_checks = 0;

  // 125 MHz clock
  initial
  begin
    forever #4 clk = ~clk;
  end
  umcs_modem dut (.core_clk_i(clk), .arst_n_i(arst_n),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .irq_o(irq), .clear_to_send_n_i(cts_n),
    .data_set_ready_n_i(dsr_n), .ring_indicator_n_i(ri_n),
    .carrier_detect_n_i(carrier_detect_n), .terminal_ready_n_o(dtr_n),
    .request_to_send_n_o(rts_n));
  umcs_mdm_model mdm (.core_clk_i(clk), .assert_i(lvl),
    .terminal_ready_n_i(dtr_n), .request_to_send_n_i(rts_n),
    .clear_to_send_n_o(cts_n), .data_set_ready_n_o(dsr_n),
    .ring_indicator_n_o(ri_n), .carrier_detect_n_o(carrier_detect_n),
    .link_up_o(link));

  // ====================
  // Shared tasks
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input umcs_word_t e, input umcs_word_t g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask
  // Request held until waitrequest is seen low; a hung slave ends the run
  task automatic bus(input logic w, input umcs_idx_t i, input umcs_word_t v,
                     output umcs_word_t r);
    int n;
    @(posedge clk);
    addr <= {i, 2'b00};
    wr <= w;
    rd <= !w;
    wdat <= v;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      failures++;
      summarize();
    end
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input umcs_idx_t i, input umcs_word_t v);
    umcs_word_t t;
    bus(1'b1, i, v, t);
  endtask
  task automatic rreg(input umcs_idx_t i, output umcs_word_t r);
    bus(1'b0, i, '0, r);
  endtask
  task automatic lines(input logic [3:0] a);
    lvl <= a;
    repeat (6) @(posedge clk);
  endtask
  function automatic umcs_word_t msr_exp(logic [3:0] a, logic [3:0] q);
    return {24'h0, a, ((a ^ q) & 4'hb) | (q & ~a & 4'h4)};
  endfunction

  // ====================
  // Scenarios
  task automatic t_reset();
    umcs_word_t r;
    chb("rts_n", 1'b1, rts_n);
    chb("dtr_n", 1'b1, dtr_n);
    chb("irq", 1'b0, irq);
    rreg(`UMCS_IDX_MCR, r);
    chk("mcr", 32'h0, r);
    rreg(`UMCS_IDX_IER, r);
    chk("ier", 32'h0, r);
    rreg(`UMCS_IDX_EVT_EN, r);
    chk("evt_en", 32'h0, r);
    $display("t_reset done");
  endtask
  task automatic t_out();
    umcs_word_t r;
    for (int v = 0; v < 4; v++)
    begin
      wreg(`UMCS_IDX_MCR, v);
      repeat (2) @(posedge clk);
      chb("dtr_n", !v[0], dtr_n);
      chb("rts_n", !v[1], rts_n);
      rreg(`UMCS_IDX_MCR, r);
      chk("mcr", v, r);
    end
    chb("link", 1'b1, link);
    wreg(`UMCS_IDX_MCR, 32'h13);
    repeat (2) @(posedge clk);
    chb("rts_n_loop", 1'b1, rts_n);
    chb("dtr_n_loop", 1'b1, dtr_n);
    rreg(`UMCS_IDX_MSR, r);
    chk("loop_msr", 32'h3, r >> 4);
    wreg(`UMCS_IDX_MCR, 32'h1c);
    repeat (2) @(posedge clk);
    rreg(`UMCS_IDX_MSR, r);
    chk("loop_aux", 32'hcb, r);
    wreg(`UMCS_IDX_MCR, 32'h0);
    lines(4'h0);
    rreg(`UMCS_IDX_MSR, r);
    chk("loop_exit", 32'hc, r);
    $display("t_out done");
  endtask
  task automatic t_stat();
    logic [3:0] pat [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf, 4'h5, 4'ha, 4'h0};
    logic [3:0] q;
    umcs_word_t r;
    q = 4'h0;
    foreach (pat[k])
    begin
      lines(pat[k]);
      rreg(`UMCS_IDX_MSR, r);
      chk("msr", msr_exp(pat[k], q), r);
      rreg(`UMCS_IDX_MSR, r);
      chk("msr_again", msr_exp(pat[k], pat[k]), r);
      q = pat[k];
    end
    $display("t_stat done");
  endtask
  task automatic t_map();
    umcs_word_t r;
    rreg(4'hf, r);
    chk("unmapped", 32'h0, r);
    wreg(4'hf, 32'hff);
    wreg(`UMCS_IDX_SCR, 32'ha5);
    rreg(`UMCS_IDX_SCR, r);
    chk("scratch", 32'ha5, r);
    wreg(`UMCS_IDX_MSR, 32'hff);
    rreg(`UMCS_IDX_MSR, r);
    chk("msr_ro", 32'h0, r);
    be <= 4'he;
    wreg(`UMCS_IDX_IER, 32'h8);
    be <= 4'hf;
    rreg(`UMCS_IDX_IER, r);
    chk("ier_be", 32'h0, r);
    $display("t_map done");
  endtask
  task automatic t_irq();
    umcs_word_t r;
    wreg(`UMCS_IDX_EVT_CLR, 32'hf);
    wreg(`UMCS_IDX_IER, 32'h8);
    lines(4'h8);
    chb("irq", 1'b1, irq);
    rreg(`UMCS_IDX_MSR, r);
    repeat (2) @(posedge clk);
    chb("irq_rd", 1'b0, irq);
    lines(4'hc);
    chb("irq_ring", 1'b1, irq);
    rreg(`UMCS_IDX_MSR, r);
    chk("msr_ring", 32'hc0, r);
    repeat (2) @(posedge clk);
    chb("irq_ring_rd", 1'b0, irq);
    lines(4'h8);
    rreg(`UMCS_IDX_MSR, r);
    chk("msr_trail", 32'h84, r);
    wreg(`UMCS_IDX_IER, 32'h0);
    wreg(`UMCS_IDX_EVT_CLR, 32'hf);
    wreg(`UMCS_IDX_EVT_EN, 32'h8);
    lines(4'h0);
    chb("irq_evt", 1'b1, irq);
    rreg(`UMCS_IDX_EVT_STAT, r);
    chk("evt_stat", 32'h8, r);
    wreg(`UMCS_IDX_EVT_EN, 32'h0);
    repeat (2) @(posedge clk);
    chb("irq_mask", 1'b0, irq);
    wreg(`UMCS_IDX_EVT_CLR, 32'h8);
    wreg(`UMCS_IDX_EVT_EN, 32'h8);
    repeat (2) @(posedge clk);
    chb("irq_clr", 1'b0, irq);
    rreg(`UMCS_IDX_EVT_STAT, r);
    chk("evt_clr", 32'h0, r);
    $display("t_irq done");
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_out();
    t_stat();
    t_map();
    t_irq();
    summarize();
  end
endmodule // uart_modem_control_status_tb
